//--- verilog/emb_ctrl.sv
// External memory bus controller driven by reset-time configuration
//
// Overview of operation
// - Nonpage: low address shares port 0 with data, high address steady on port 2.
// - Page: low address steady on port 0, high address shares port 2 with data.
// - The address latch strobe pulses at the start of each bus cycle except a page-mode hit, while the address is valid.
// - The external access strap, caught at reset, sends fetches off-chip when low or outside on-chip code.
// - Bit 1 of configuration byte zero set selects nonpage mode with two-state code fetches.
// - In page mode a code fetch to the same page as the previous fetch takes one state.
// - Bits 2 and 3 of configuration byte zero pick the strobe map, with 00 reserved.
// - Only the low 16 address bits reach the external address pins, except under map 01.
// - Map 01 turns the data-read pin into address bit 16 and uses the code-read strobe for all reads.
// - Map 01 places internal address bit 16 on the extra address pin.
// - Map 10 leaves the data-read pin as a port bit and uses the code-read strobe for all reads.
// - Map 11 fires data-read below 80:0000H and code-read from there upward.
// - The code-read strobe is always a read strobe, also for data under maps 01 and 10.
// - Map 11 fires the write strobe only for regions 00: and 01:, other maps for all writes.
`timescale 1ns/10ps
`include "emb_params.svh"
module emb_ctrl
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  configuration_byte_zero,
   input  wire logic        external_access_select_n,
   input  wire logic [15:0] code_top,
   input  wire logic        req_valid,
   input  wire logic        req_write,
   input  wire logic        req_code,
   input  wire logic [23:0] req_addr,
   input  wire logic [7:0]  req_wdata,
   output logic             req_ready,
   output logic             rsp_valid,
   output logic [7:0]       rsp_rdata,
   output logic             fetch_internal,
   output logic             map_reserved,
   input  wire logic        spare_port_bit_out,
   input  wire logic [7:0]  p0_in,
   output logic [7:0]       p0_out,
   output logic             p0_oe,
   input  wire logic [7:0]  p2_in,
   output logic [7:0]       p2_out,
   output logic             p2_oe,
   output logic             address_latch_strobe,
   output logic             code_read_strobe_n,
   output logic             data_read_pin,
   output logic             write_strobe_n
);
   // ==========================================================
   // Configuration capture
   logic              cfg_taken;
   logic              nonpage;
   logic [1:0]        map;
   logic              ea_n;
   // Catch configuration once after reset release
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_taken <= 1'b0;
         nonpage   <= 1'b1;
         map       <= 2'b11;
         ea_n      <= 1'b0;
      end
      else if (!cfg_taken)
      begin
         cfg_taken <= 1'b1;
         nonpage   <= configuration_byte_zero[`EMB_CFG0_PAGE_BIT];
         map       <= configuration_byte_zero[`EMB_CFG0_MAP_HI_BIT:`EMB_CFG0_MAP_LO_BIT];
         ea_n      <= external_access_select_n;
      end
   end
   assign map_reserved = cfg_taken && (map == 2'(emb_pkg::EMB_MAP_RSVD));

   // ==========================================================
   // Strobe decode
   logic              use_code_rd;
   logic              use_data_rd;
   logic              use_wr;
   emb_strobe_decode u_dec
   (
      .map         (map),
      .addr        (req_addr),
      .is_write    (req_write),
      .use_code_rd (use_code_rd),
      .use_data_rd (use_data_rd),
      .use_wr      (use_wr)
   );

   // Internal fetch when strap high and inside on-chip code
   logic              next_internal;
   assign next_internal = req_code && !req_write && ea_n
                          && (req_addr[23:16] == 8'hFF) && (req_addr[15:0] <= code_top);

   // ==========================================================
   // Bus cycle sequencer
   emb_pkg::emb_state_t state;
   logic [15:0]       addr;
   logic              a16;
   logic [7:0]        wdata;
   logic              cyc_write;
   logic              cyc_code;
   logic              cyc_crd;
   logic              cyc_drd;
   logic              cyc_wr;
   logic              page_valid;
   logic [23:8]       page_tag;
   logic              hit;
   logic              accept;
   assign hit    = !nonpage && page_valid && req_code && !req_write
                   && (req_addr[23:8] == page_tag);
   assign req_ready = cfg_taken && !map_reserved && (state == emb_pkg::EMB_IDLE);
   assign accept = req_valid && req_ready && !next_internal;
   // Internal fetches answer at once from the core, no bus activity
   assign fetch_internal = req_valid && req_ready && next_internal;

   // State progression
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         state <= emb_pkg::EMB_IDLE;
      else
      begin
         unique case (state)
            emb_pkg::EMB_IDLE:
               if (accept)
                  state <= hit ? emb_pkg::EMB_STROBE : emb_pkg::EMB_ADDR;
            emb_pkg::EMB_ADDR:    state <= emb_pkg::EMB_STROBE;
            emb_pkg::EMB_STROBE:  state <= cyc_write ? emb_pkg::EMB_RECOVER : emb_pkg::EMB_IDLE;
            emb_pkg::EMB_RECOVER: state <= emb_pkg::EMB_IDLE;
         endcase
      end
   end

   // Latch access attributes at acceptance
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         addr      <= 16'h0000;
         a16       <= 1'b0;
         wdata     <= 8'h00;
         cyc_write <= 1'b0;
         cyc_code  <= 1'b0;
         cyc_crd   <= 1'b0;
         cyc_drd   <= 1'b0;
         cyc_wr    <= 1'b0;
      end
      else if (accept)
      begin
         addr      <= req_addr[15:0];
         a16       <= req_addr[`EMB_A16_BIT];
         wdata     <= req_wdata;
         cyc_write <= req_write;
         cyc_code  <= req_code;
         cyc_crd   <= use_code_rd;
         cyc_drd   <= use_data_rd;
         cyc_wr    <= use_wr;
      end
   end

   // Page tracking; data cycles break the page
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         page_valid <= 1'b0;
         page_tag   <= 16'h0000;
      end
      else if (accept)
      begin
         page_valid <= req_code && !req_write && !nonpage;
         page_tag   <= req_addr[23:8];
      end
   end

   // Read data capture and answer pulse
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rsp_valid <= 1'b0;
         rsp_rdata <= 8'h00;
      end
      else
      begin
         rsp_valid <= (state == emb_pkg::EMB_STROBE) && !cyc_write;
         if ((state == emb_pkg::EMB_STROBE) && !cyc_write)
            rsp_rdata <= nonpage ? p0_in : p2_in;
      end
   end

   // ==========================================================
   // Pin drive
   logic              in_addr;
   logic              in_data;
   logic              active;
   assign in_addr = (state == emb_pkg::EMB_ADDR);
   assign in_data = (state == emb_pkg::EMB_STROBE) || (state == emb_pkg::EMB_RECOVER);
   assign active  = in_addr || in_data;
   assign address_latch_strobe = in_addr;

   // Port drive: multiplexed byte shows address then write data
   always_comb
   begin
      p0_out = 8'h00;
      p0_oe  = 1'b0;
      p2_out = 8'h00;
      p2_oe  = 1'b0;
      if (active)
      begin
         if (nonpage)
         begin
            p2_out = addr[15:8];
            p2_oe  = 1'b1;
            p0_out = in_addr ? addr[7:0] : wdata;
            p0_oe  = in_addr || cyc_write;
         end
         else
         begin
            p0_out = addr[7:0];
            p0_oe  = 1'b1;
            p2_out = in_addr ? addr[15:8] : wdata;
            p2_oe  = in_addr || cyc_write;
         end
      end
   end

   // Strobes
   assign code_read_strobe_n = !((state == emb_pkg::EMB_STROBE) && !cyc_write && cyc_crd);
   assign write_strobe_n     = !((state == emb_pkg::EMB_STROBE) && cyc_write && cyc_wr);
   always_comb
   begin
      unique case (map)
         2'(emb_pkg::EMB_MAP_A16):  data_read_pin = a16;
         2'(emb_pkg::EMB_MAP_PORT): data_read_pin = spare_port_bit_out;
         2'(emb_pkg::EMB_MAP_SPLIT):
            data_read_pin = !((state == emb_pkg::EMB_STROBE) && !cyc_write && cyc_drd);
         default:                   data_read_pin = 1'b1;
      endcase
   end

   // ==========================================================
   // Checks
   property p_ale_then_strobe;
      @(posedge sys_clk) disable iff (!rst_n)
      address_latch_strobe |=> (state == emb_pkg::EMB_STROBE) && !address_latch_strobe;
   endproperty
   a_ale_then_strobe: assert property (p_ale_then_strobe) else $error("latch strobe not followed by strobe state");
   property p_nonpage_two_state;
      @(posedge sys_clk) disable iff (!rst_n)
      (accept && nonpage) |=> address_latch_strobe;
   endproperty
   a_nonpage_two_state: assert property (p_nonpage_two_state) else $error("nonpage cycle skipped address state");
   property p_page_hit_one;
      @(posedge sys_clk) disable iff (!rst_n)
      (accept && hit) |=> !address_latch_strobe && (state == emb_pkg::EMB_STROBE) && !cyc_write;
   endproperty
   a_page_hit_one: assert property (p_page_hit_one) else $error("page hit not one state");
   property p_cfg_stable;
      @(posedge sys_clk) disable iff (!rst_n)
      $past(cfg_taken) |-> $stable(map) && $stable(nonpage);
   endproperty
   a_cfg_stable: assert property (p_cfg_stable) else $error("configuration changed after capture");
   property p_np_high_addr;
      @(posedge sys_clk) disable iff (!rst_n)
      (nonpage && in_data) |-> p2_oe && (p2_out == $past(p2_out));
   endproperty
   a_np_high_addr: assert property (p_np_high_addr) else $error("high address not held in nonpage");
   property p_pg_low_addr;
      @(posedge sys_clk) disable iff (!rst_n)
      (!nonpage && active) |-> p0_oe && (p0_out == addr[7:0]);
   endproperty
   a_pg_low_addr: assert property (p_pg_low_addr) else $error("low address not held in page mode");
   property p_split_write;
      @(posedge sys_clk) disable iff (!rst_n)
      (accept && req_write && map == 2'b11 && req_addr[23]) |=> write_strobe_n [*3];
   endproperty
   a_split_write: assert property (p_split_write) else $error("write strobe fired in code region");
   property p_a16_pin;
      @(posedge sys_clk) disable iff (!rst_n)
      (map == 2'b01 && active) |-> data_read_pin == a16;
   endproperty
   a_a16_pin: assert property (p_a16_pin) else $error("extra address pin wrong");
   property p_split_read;
      @(posedge sys_clk) disable iff (!rst_n)
      (accept && !req_write && map == 2'b11) |=> ##[0:1] (code_read_strobe_n != data_read_pin);
   endproperty
   a_split_read: assert property (p_split_read) else $error("split read strobes wrong");
   property p_internal_quiet;
      @(posedge sys_clk) disable iff (!rst_n)
      fetch_internal |=> !address_latch_strobe && (state == emb_pkg::EMB_IDLE);
   endproperty
   a_internal_quiet: assert property (p_internal_quiet) else $error("internal fetch used the bus");
   c_write: cover property (@(posedge sys_clk) disable iff (!rst_n) !write_strobe_n);
   c_hit: cover property (@(posedge sys_clk) disable iff (!rst_n) accept && hit);
   c_data_rd: cover property (@(posedge sys_clk) disable iff (!rst_n) map == 2'b11 && !data_read_pin);
   c_internal: cover property (@(posedge sys_clk) disable iff (!rst_n) fetch_internal);
   property p_reserved_quiet;
      @(posedge sys_clk) disable iff (!rst_n)
      map_reserved |-> !req_ready && !address_latch_strobe && code_read_strobe_n && write_strobe_n;
   endproperty
   a_reserved_quiet: assert property (p_reserved_quiet) else $error("bus active under reserved strobe map");
endmodule : emb_ctrl

//--- verilog/emb_params.svh
// Constants for the external memory bus configuration block
`ifndef EMB_PARAMS_SVH
`define EMB_PARAMS_SVH
`define EMB_CFG0_PAGE_BIT    1
`define EMB_CFG0_MAP_LO_BIT  2
`define EMB_CFG0_MAP_HI_BIT  3
`define EMB_CFG0_RESET       8'hFF
`define EMB_UPPER_HALF_BIT   23
`define EMB_A16_BIT          16
`define EMB_WRITE_REGION_HI  8'h01
`define EMB_CODE_TOP_DEFAULT 16'h3FFF
`endif

//--- verilog/emb_pkg.sv
// Types for the external memory bus configuration block
package emb_pkg;
   typedef enum logic [1:0] {EMB_MAP_RSVD, EMB_MAP_A16, EMB_MAP_PORT, EMB_MAP_SPLIT} emb_map_t;
   typedef enum {EMB_IDLE, EMB_ADDR, EMB_STROBE, EMB_RECOVER} emb_state_t;
endpackage : emb_pkg

//--- verilog/emb_strobe_decode.sv
// Region decode: which strobes fire for an access
`timescale 1ns/10ps
`include "emb_params.svh"
module emb_strobe_decode
(
   input  wire logic [1:0]  map,
   input  wire logic [23:0] addr,
   input  wire logic        is_write,
   output logic             use_code_rd,
   output logic             use_data_rd,
   output logic             use_wr
);
   // Read and write strobe selection by strobe map
   always_comb
   begin
      use_code_rd = 1'b0;
      use_data_rd = 1'b0;
      use_wr      = 1'b0;
      if (is_write)
      begin
         if (map == 2'(emb_pkg::EMB_MAP_SPLIT))
            use_wr = (addr[23:16] <= `EMB_WRITE_REGION_HI);
         else
            use_wr = 1'b1;
      end
      else if (map == 2'(emb_pkg::EMB_MAP_SPLIT))
      begin
         use_data_rd = ~addr[`EMB_UPPER_HALF_BIT];
         use_code_rd = addr[`EMB_UPPER_HALF_BIT];
      end
      else
         use_code_rd = 1'b1;
   end
endmodule : emb_strobe_decode

//--- sim/emb_mem_model.sv
// Behavioural external memory with address latch for the bus controller
`timescale 1ns/10ps
module emb_mem_model
(
   input  wire logic       sys_clk,
   input  wire logic [1:0] map,
   input  wire logic       page,
   input  wire logic [7:0] p0_out,
   input  wire logic [7:0] p2_out,
   input  wire logic       address_latch_strobe,
   input  wire logic       code_read_strobe_n,
   input  wire logic       data_read_pin,
   input  wire logic       write_strobe_n,
   output logic [7:0]      p0_in,
   output logic [7:0]      p2_in
);
   logic [7:0]  mem [0:131071];
   logic [15:0] lat;
   logic        a16 = 1'b0;
   logic [7:0]  last = 8'h00;
   logic        rd;
   logic [16:0] addr;
   // Page hits keep the latched high byte and take the low byte live
   assign addr = {a16, lat[15:8], page ? p0_out : lat[7:0]};
   assign rd   = !code_read_strobe_n || (map == 2'b11 && !data_read_pin);
   // Released bus shows the inverse of the last byte, never a stale copy
   assign p0_in = rd ? mem[addr] : ~last;
   assign p2_in = rd ? mem[addr] : ~last;
   // Address latch and write capture
   always @(posedge sys_clk)
   begin
      if (address_latch_strobe)
      begin
         lat <= {p2_out, p0_out};
         a16 <= (map == 2'b01) ? data_read_pin : 1'b0;
      end
      if (!write_strobe_n)
         mem[addr] <= page ? p2_out : p0_out;
      if (rd)
         last <= mem[addr];
   end
endmodule : emb_mem_model

//--- sim/emb_ctrl_tb_top.sv
// Self-checking testbench for the external memory bus controller
`timescale 1ns/10ps
module emb_ctrl_tb_top;
   logic        sys_clk, rst_n, ext_n, req_valid, req_write, req_code, req_ready, rsp_valid, spare;
   logic        fetch_internal, map_reserved, p0_oe, p2_oe, ale, crs_n, drp, ws_n, page, a16_seen;
   logic [7:0]  cfg, req_wdata, rsp_rdata, p0_in, p0_out, p2_in, p2_out, rd_val, ale_p0, ale_p2;
   logic [15:0] code_top;
   logic [23:0] req_addr;
   logic [1:0]  cur_map, ale_oe, rd_oe;
   int          n_errors, checked, n_ale, n_code, n_data, n_wr, n_int, lat_k;

   emb_ctrl uut (.sys_clk(sys_clk), .rst_n(rst_n), .configuration_byte_zero(cfg),
      .external_access_select_n(ext_n), .code_top(code_top), .req_valid(req_valid),
      .req_write(req_write), .req_code(req_code), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .fetch_internal(fetch_internal), .map_reserved(map_reserved), .spare_port_bit_out(spare),
      .p0_in(p0_in), .p0_out(p0_out), .p0_oe(p0_oe), .p2_in(p2_in), .p2_out(p2_out), .p2_oe(p2_oe),
      .address_latch_strobe(ale), .code_read_strobe_n(crs_n), .data_read_pin(drp),
      .write_strobe_n(ws_n));
   emb_mem_model mem (.sys_clk(sys_clk), .map(cur_map), .page(page), .p0_out(p0_out),
      .p2_out(p2_out), .address_latch_strobe(ale), .code_read_strobe_n(crs_n),
      .data_read_pin(drp), .write_strobe_n(ws_n), .p0_in(p0_in), .p2_in(p2_in));

   // Clock
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // Bus activity counters for the current transfer
   always @(posedge sys_clk)
   begin
      if (ale === 1'b1)
      begin
         n_ale++;
         ale_p0 = p0_out;
         ale_p2 = p2_out;
         ale_oe = {p2_oe, p0_oe};
      end
      if (crs_n === 1'b0)
      begin
         n_code++;
         a16_seen = drp;
      end
      if (cur_map == 2'b11 && drp === 1'b0) n_data++;
      if (ws_n === 1'b0) n_wr++;
      if (fetch_internal === 1'b1) n_int++;
      // Port drive while a read strobe is low
      if (crs_n === 1'b0 || (cur_map == 2'b11 && drp === 1'b0))
         rd_oe = {p2_oe, p0_oe};
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic report_and_stop();
      $display("errors=%0d checks=%0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop

   task automatic do_reset(input logic [7:0] c, input logic e);
      rst_n = 1'b0;
      cfg = c;
      ext_n = e;
      cur_map = c[3:2];
      page = ~c[1];
      repeat (4) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : do_reset

   // One request, held until taken, then wait for its completion
   task automatic access(input logic w, input logic c, input logic [23:0] a, input logic [7:0] d);
      int k;
      n_ale = 0; n_code = 0; n_data = 0; n_wr = 0; n_int = 0;
      req_valid = 1'b1; req_write = w; req_code = c; req_addr = a; req_wdata = d;
      k = 0;
      while (req_ready !== 1'b1 && fetch_internal !== 1'b1 && k < 20)
      begin
         @(posedge sys_clk);
         #1 k++;
      end
      if (k == 20)
      begin
         n_errors++;
         report_and_stop();
      end
      @(posedge sys_clk);
      #1 req_valid = 1'b0;
      lat_k = 0;
      while (!(w ? req_ready === 1'b1 : (rsp_valid === 1'b1 || n_int > 0)) && lat_k < 20)
      begin
         @(posedge sys_clk);
         #1 lat_k++;
      end
      if (lat_k == 20)
      begin
         n_errors++;
         report_and_stop();
      end
      rd_val = rsp_rdata;
      // Let an edge pass so the next request never follows a release in one step
      @(posedge sys_clk);
      #1;
   endtask : access

   initial
   begin
      req_valid = 1'b0; req_write = 1'b0; req_code = 1'b0; req_addr = 24'h00_0000;
      req_wdata = 8'h00; spare = 1'b0; code_top = 16'h3FFF; n_errors = 0; checked = 0;
      // Split map, nonpage
      do_reset(8'h0E, 1'b0);
      access(1'b1, 1'b0, 24'h00_1234, 8'hA5);
      chk(n_wr, 1);
      chk({ale_p2, ale_p0}, 16'h1234);
      chk(n_ale, 1);
      access(1'b1, 1'b0, 24'hFE_1234, 8'h11);
      chk(n_wr, 0);
      access(1'b0, 1'b0, 24'h01_1234, 8'h00);
      chk(rd_val, 8'hA5);
      chk(n_data, 1);
      chk(n_code, 0);
      chk({ale_oe, rd_oe}, 4'b1110);
      chk(lat_k, 2);
      access(1'b0, 1'b1, 24'hFF_1234, 8'h00);
      chk(n_data, 0);
      chk(n_code, 1);
      chk(rd_val, 8'hA5);
      cfg = 8'h00;
      chk(map_reserved, 1'b0);
      access(1'b0, 1'b0, 24'h00_1234, 8'h00);
      chk(n_data, 1);
      // Reserved map refuses the bus
      do_reset(8'h02, 1'b0);
      chk({map_reserved, req_ready}, 2'b10);
      // Seventeen address bits
      do_reset(8'h06, 1'b0);
      access(1'b1, 1'b0, 24'h01_4000, 8'h3C);
      access(1'b1, 1'b0, 24'h00_4000, 8'hC3);
      access(1'b0, 1'b0, 24'hFF_4000, 8'h00);
      chk({rd_val, a16_seen}, {8'h3C, 1'b1});
      chk(n_code, 1);
      access(1'b0, 1'b1, 24'hFE_4000, 8'h00);
      chk({rd_val, a16_seen}, {8'hC3, 1'b0});
      // Port-bit map
      do_reset(8'h0A, 1'b0);
      spare = 1'b1;
      @(posedge sys_clk);
      #1 chk(drp, 1'b1);
      spare = 1'b0;
      @(posedge sys_clk);
      #1 chk(drp, 1'b0);
      access(1'b1, 1'b0, 24'h00_0100, 8'h77);
      access(1'b0, 1'b0, 24'hFE_0100, 8'h00);
      chk({rd_val, n_code[7:0]}, {8'h77, 8'h01});
      // Page mode: structure, miss then hit
      do_reset(8'h0C, 1'b0);
      access(1'b1, 1'b0, 24'h00_2011, 8'hA6);
      access(1'b1, 1'b0, 24'h00_2010, 8'h5A);
      chk({ale_p2, ale_p0}, 16'h2010);
      access(1'b0, 1'b1, 24'hFF_2010, 8'h00);
      chk({rd_val, lat_k[7:0]}, {8'h5A, 8'h02});
      chk({ale_oe, rd_oe}, 4'b1101);
      access(1'b0, 1'b1, 24'hFF_2011, 8'h00);
      chk({rd_val, lat_k[7:0], n_ale[7:0]}, {8'hA6, 8'h01, 8'h00});
      // On-chip code with strap high
      do_reset(8'h0E, 1'b1);
      access(1'b0, 1'b1, 24'hFF_0010, 8'h00);
      chk(n_int, 1);
      chk(n_ale, 0);
      access(1'b0, 1'b1, 24'hFF_4000, 8'h00);
      chk(n_int, 0);
      chk(n_ale, 1);
      report_and_stop();
   end
endmodule : emb_ctrl_tb_top
